// File: logic/sfsr_pkg.sv
// Purpose: Shared constants for the flash status register block
// Assumes: 100 MHz core clock, serial link in mode 0
// Notes:   Opcode table order matters, program/erase entries come first
`default_nettype none
package sfsr_pkg;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int NV_WRITE_NS   = 2000;
   // Least time, so round up
   localparam int NV_WRITE_CYC  =
      (NV_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ************************************************************
   // Status register layout
   // ************************************************************
   localparam int BIT_BUSY     = 0;
   localparam int BIT_WEL      = 1;
   localparam int BIT_PROT_LO  = 2;
   localparam int BIT_PROT_HI  = 5;
   localparam int BIT_QUAD     = 6;
   localparam int BIT_SWD      = 7;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [3:0] PROT_NONE    = 4'h0;

   // ************************************************************
   // Opcodes
   // ************************************************************
   localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_WRITE_STATUS  = 8'h01;
   localparam logic [7:0] OP_READ_STATUS   = 8'h05;
   localparam logic [7:0] OP_SUSPEND       = 8'h75;
   localparam logic [7:0] OP_RESUME        = 8'h7A;
   localparam logic [7:0] OP_RESET_ENABLE  = 8'h66;
   localparam logic [7:0] OP_RESET         = 8'h99;
   localparam logic [7:0] OP_ERASE_ALL_A   = 8'hC7;
   localparam logic [7:0] OP_ERASE_ALL_B   = 8'h60;

   // Write-type opcodes; the first PE_COUNT are program or erase
   localparam int PE_COUNT = 15;
   localparam int WR_COUNT = 38;
   localparam logic [7:0] WRITE_OPS [WR_COUNT] = '{
      8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3E, 8'hD7, 8'h20,
      8'h21, 8'h52, 8'h5C, 8'hD8, 8'hDC, 8'hC7, 8'h60,
      8'h01, 8'h42, 8'h65, 8'h63, 8'h85, 8'h83, 8'h64, 8'h62,
      8'h18, 8'hC5, 8'hFB, 8'hE1, 8'hFD, 8'hE3, 8'hE4, 8'h2F,
      8'hA6, 8'h91, 8'h7E, 8'h98, 8'hE8, 8'h43, 8'h4A};

   // ************************************************************
   // Link framing
   // ************************************************************
   localparam logic [2:0] BIT_LAST  = 3'h7;
   localparam logic [1:0] IDX_OPC   = 2'h0;
   localparam logic [1:0] IDX_DATA  = 2'h1;
   localparam logic [1:0] IDX_MAX   = 2'h2;
   localparam logic [1:0] GOT_NONE  = 2'h0;
   localparam logic [1:0] GOT_OPC   = 2'h1;
   localparam logic [1:0] GOT_DATA  = 2'h2;

   typedef enum logic [1:0] {
      ST_IDLE, ST_NVWRITE, ST_ENGINE, ST_SUSPENDED
   } sfsr_state_t;

   function automatic logic isWriteType(input logic [7:0] op);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < WR_COUNT; i++) begin
         if (WRITE_OPS[i] == op) hit = 1'b1;
      end
      return hit;
   endfunction

   function automatic logic isProgErase(input logic [7:0] op);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < PE_COUNT; i++) begin
         if (WRITE_OPS[i] == op) hit = 1'b1;
      end
      return hit;
   endfunction

endpackage
`default_nettype wire

// File: logic/sfsr_link_if.sv
// Purpose: Carrier between link-side shifter and core logic
// Assumes: opc/dat/got are read by the core only after frame end
// Notes:   shadow/req/ack form a request-acknowledge word crossing
`timescale 1ns/100ps
`default_nettype none
interface sfsr_link_if;
   logic [7:0] opc;
   logic [7:0] dat;
   logic [1:0] got;
   logic       aligned;
   logic [7:0] shadow;
   logic       req;
   logic       ack;

   modport link (
      output opc,
      output dat,
      output got,
      output aligned,
      output ack,
      input  shadow,
      input  req
   );

   modport core (
      input  opc,
      input  dat,
      input  got,
      input  aligned,
      input  ack,
      output shadow,
      output req
   );
endinterface
`default_nettype wire

// File: logic/sfsr_link.sv
// Purpose: Serial link shifter on the link clock
// Assumes: Mode 0, sample on rising edge, drive on falling edge
// Notes:   Chip enable high resets framing state asynchronously
`timescale 1ns/100ps
`default_nettype none
module sfsr_link (
   input  wire logic   sck,
   input  wire logic   rst_n,
   input  wire logic   csN,
   input  wire logic   si,
   output var  logic   soOut,
   output var  logic   soOe,
   sfsr_link_if.link   bus
);
   logic       frameRst_n;
   logic [2:0] bitCnt_q;
   logic [1:0] byteIdx_q;
   logic [6:0] sh_q;
   logic       reading_q;
   logic [7:0] rxByte;
   logic       byteEnd;
   logic [7:0] outByte_q;
   logic [7:0] view_q;
   logic       reqS1_q;
   logic       reqS2_q;
   logic [7:0] opc_q;
   logic [7:0] dat_q;
   logic [1:0] got_q;
   logic       aligned_q;
   logic       ack_q;

   assign frameRst_n = rst_n & ~csN;
   assign rxByte     = {sh_q, si};
   assign byteEnd    = (bitCnt_q == sfsr_pkg::BIT_LAST);
   assign bus.opc     = opc_q;
   assign bus.dat     = dat_q;
   assign bus.got     = got_q;
   assign bus.aligned = aligned_q;
   assign bus.ack     = ack_q;

   // ************************************************************
   // Framing
   // ************************************************************
   always_ff @(posedge sck or negedge frameRst_n) begin
      if (!frameRst_n) begin
         bitCnt_q  <= '0;
         byteIdx_q <= sfsr_pkg::IDX_OPC;
         sh_q      <= '0;
         reading_q <= 1'b0;
      end else begin
         sh_q     <= rxByte[6:0];
         bitCnt_q <= 3'(bitCnt_q + 3'h1);
         if (byteEnd && byteIdx_q != sfsr_pkg::IDX_MAX) begin
            byteIdx_q <= 2'(byteIdx_q + 2'h1);
         end
         if (byteEnd && byteIdx_q == sfsr_pkg::IDX_OPC) begin
            reading_q <= (rxByte == sfsr_pkg::OP_READ_STATUS);
         end
      end
   end

   // ************************************************************
   // Captured instruction, held past frame end for the core
   // ************************************************************
   always_ff @(posedge sck or negedge rst_n) begin
      if (!rst_n) begin
         opc_q     <= '0;
         dat_q     <= '0;
         got_q     <= sfsr_pkg::GOT_NONE;
         aligned_q <= 1'b0;
         outByte_q <= sfsr_pkg::STATUS_RESET;
      end else begin
         aligned_q <= byteEnd;
         if (bitCnt_q == '0 && byteIdx_q == sfsr_pkg::IDX_OPC) begin
            got_q <= sfsr_pkg::GOT_NONE;
         end
         if (byteEnd && byteIdx_q == sfsr_pkg::IDX_OPC) begin
            opc_q     <= rxByte;
            got_q     <= sfsr_pkg::GOT_OPC;
            outByte_q <= view_q;  // Frozen for the whole frame
         end
         if (byteEnd && byteIdx_q == sfsr_pkg::IDX_DATA) begin
            dat_q <= rxByte;
            got_q <= sfsr_pkg::GOT_DATA;
         end
      end
   end

   // ************************************************************
   // Status word crossing
   // ************************************************************
   // Stalls while the link clock stops; completes within three edges
   always_ff @(posedge sck or negedge rst_n) begin
      if (!rst_n) begin
         reqS1_q <= 1'b0;
         reqS2_q <= 1'b0;
         ack_q   <= 1'b0;
         view_q  <= sfsr_pkg::STATUS_RESET;
      end else begin
         reqS1_q <= bus.req;
         reqS2_q <= reqS1_q;
         if (reqS2_q != ack_q) begin
            view_q <= bus.shadow;
            ack_q  <= reqS2_q;
         end
      end
   end

   // ************************************************************
   // Output, MSB first, wraps forever
   // ************************************************************
   always_ff @(negedge sck or negedge frameRst_n) begin
      if (!frameRst_n) begin
         soOut <= 1'b0;
         soOe  <= 1'b0;
      end else begin
         soOe  <= reading_q;
         soOut <= reading_q & outByte_q[~bitCnt_q];
      end
   end
endmodule // sfsr_link
`default_nettype wire

// File: logic/sfsr_core.sv
// Purpose: Status register and write-enable latch of a serial flash
// Assumes: Engine signals on clk; chip enable high at least 4 clk
// Notes:   Nonvolatile bits modelled as flops cleared at power-on
`timescale 1ns/100ps
`default_nettype none
module sfsr_core #(
   parameter int NV_WRITE_CYC = sfsr_pkg::NV_WRITE_CYC
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       sck,
   input  wire logic       csN,
   input  wire logic       si,
   output var  logic       soOut,
   output var  logic       soOe,
   input  wire logic       wpN,
   output var  logic       io2Out,
   output var  logic       io2Oe,
   input  wire logic       holdRstN,
   output var  logic       io3Out,
   output var  logic       io3Oe,
   output var  logic       engStart,
   output var  logic [7:0] engOpcode,
   output var  logic       engSuspend,
   output var  logic       engResume,
   output var  logic       engAbort,
   input  wire logic       engDone,
   input  wire logic       engSuspended,
   output var  logic [7:0] flashStatus,
   output var  logic [3:0] protectLevel,
   output var  logic       quadMode
);
   localparam int NSYNC = 4;
   localparam logic [NSYNC-1:0] SYNC_INIT = 4'h7;
   localparam int CW = $clog2(NV_WRITE_CYC + 1);
   localparam logic [CW-1:0] NV_LOAD = CW'(NV_WRITE_CYC - 1);

   sfsr_link_if ifc();

   logic [NSYNC-1:0]        syncIn;
   logic [NSYNC-1:0]        syncS1_q;
   logic [NSYNC-1:0]        syncS2_q;
   logic                    csPrev_q;
   logic                    csRise;
   logic                    wpLow;
   logic                    hwRst;
   logic                    ackSync;
   sfsr_pkg::sfsr_state_t   state_q;
   logic [sfsr_pkg::BIT_SWD:sfsr_pkg::BIT_PROT_LO] nvBits_q;
   logic                    wel_q;
   logic [7:0]              runOp_q;
   logic [CW-1:0]           nvCnt_q;
   logic                    armed_q;
   logic [7:0]              shadow_q;
   logic                    req_q;
   logic [7:0]              statusNow;
   logic [7:0]              op;
   logic                    cmdOk;
   logic                    busy;
   logic                    idle;
   logic                    locked;
   logic                    nvDone;
   logic                    engFin;
   logic                    doWren;
   logic                    doWrdi;
   logic                    doWrsr;
   logic                    doEng;
   logic                    doSusp;
   logic                    doResume;
   logic                    doRst;

   sfsr_link u_link (
      .sck   (sck),
      .rst_n (rst_n),
      .csN   (csN),
      .si    (si),
      .soOut (soOut),
      .soOe  (soOe),
      .bus   (ifc.link)
   );

   // ************************************************************
   // Pin and acknowledge synchronisers
   // ************************************************************
   assign syncIn = {ifc.ack, holdRstN, wpN, csN};

   for (genvar i = 0; i < NSYNC; i++) begin : g_sync
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            syncS1_q[i] <= SYNC_INIT[i];
            syncS2_q[i] <= SYNC_INIT[i];
         end else begin
            syncS1_q[i] <= syncIn[i];
            syncS2_q[i] <= syncS1_q[i];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         csPrev_q <= 1'b1;
      end else begin
         csPrev_q <= syncS2_q[0];
      end
   end

   // Frame end: link clock has stopped, captured fields are stable
   assign csRise  = syncS2_q[0] & ~csPrev_q;
   assign ackSync = syncS2_q[3];
   // Shared pins only act as controls with quad mode off
   assign wpLow   = ~syncS2_q[1] & ~nvBits_q[sfsr_pkg::BIT_QUAD];
   assign hwRst   = ~syncS2_q[2] & ~nvBits_q[sfsr_pkg::BIT_QUAD];

   // ************************************************************
   // Instruction decode at frame end
   // ************************************************************
   always_comb begin
      op     = ifc.opc;
      cmdOk  = csRise & ifc.aligned & (ifc.got != sfsr_pkg::GOT_NONE);
      busy   = (state_q == sfsr_pkg::ST_NVWRITE) ||
               (state_q == sfsr_pkg::ST_ENGINE);
      idle   = (state_q == sfsr_pkg::ST_IDLE);
      locked = nvBits_q[sfsr_pkg::BIT_SWD] & wpLow;
      nvDone = (state_q == sfsr_pkg::ST_NVWRITE) && (nvCnt_q == '0);
      engFin = (state_q == sfsr_pkg::ST_ENGINE) && engDone;
      // Busy gates everything but suspend and reset
      doWren = cmdOk & ~busy & (op == sfsr_pkg::OP_WRITE_ENABLE);
      doWrdi = cmdOk & ~busy & (op == sfsr_pkg::OP_WRITE_DISABLE);
      doWrsr = cmdOk & idle & wel_q & ~locked &
               (op == sfsr_pkg::OP_WRITE_STATUS) &
               (ifc.got == sfsr_pkg::GOT_DATA);
      doEng  = cmdOk & idle & wel_q &
               sfsr_pkg::isWriteType(op) &
               (op != sfsr_pkg::OP_WRITE_STATUS);
      if ((op == sfsr_pkg::OP_ERASE_ALL_A ||
           op == sfsr_pkg::OP_ERASE_ALL_B) &&
          nvBits_q[sfsr_pkg::BIT_PROT_HI:sfsr_pkg::BIT_PROT_LO]
             != sfsr_pkg::PROT_NONE) begin
         doEng = 1'b0;
      end
      doSusp   = cmdOk & (state_q == sfsr_pkg::ST_ENGINE) &
                 sfsr_pkg::isProgErase(runOp_q) &
                 (op == sfsr_pkg::OP_SUSPEND);
      doResume = cmdOk & (state_q == sfsr_pkg::ST_SUSPENDED) &
                 (op == sfsr_pkg::OP_RESUME);
      doRst    = hwRst | (cmdOk & armed_q &
                 (op == sfsr_pkg::OP_RESET));
   end

   // ************************************************************
   // Operation sequencing
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= sfsr_pkg::ST_IDLE;
      end else if (doRst) begin
         state_q <= sfsr_pkg::ST_IDLE;
      end else begin
         unique case (state_q)
            sfsr_pkg::ST_IDLE: begin
               if (doWrsr) begin
                  state_q <= sfsr_pkg::ST_NVWRITE;
               end else if (doEng) begin
                  state_q <= sfsr_pkg::ST_ENGINE;
               end
            end
            sfsr_pkg::ST_NVWRITE: begin
               if (nvDone) state_q <= sfsr_pkg::ST_IDLE;
            end
            sfsr_pkg::ST_ENGINE: begin
               // Pass or fail alike end the busy period
               if (engDone) begin
                  state_q <= sfsr_pkg::ST_IDLE;
               end else if (engSuspended) begin
                  state_q <= sfsr_pkg::ST_SUSPENDED;
               end
            end
            sfsr_pkg::ST_SUSPENDED: begin
               if (doResume) state_q <= sfsr_pkg::ST_ENGINE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         nvCnt_q <= '0;
      end else if (doWrsr) begin
         nvCnt_q <= NV_LOAD;
      end else if (state_q == sfsr_pkg::ST_NVWRITE && nvCnt_q != '0) begin
         nvCnt_q <= CW'(nvCnt_q - 1'b1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         runOp_q <= '0;
      end else if (doEng) begin
         runOp_q <= op;
      end
   end

   // Reset needs an enable frame immediately before it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         armed_q <= 1'b0;
      end else if (cmdOk) begin
         armed_q <= (op == sfsr_pkg::OP_RESET_ENABLE);
      end
   end

   // ************************************************************
   // Write-enable latch and nonvolatile bits
   // ************************************************************
   // Status write leaves the latch set until its write time ends
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wel_q <= 1'b0;
      end else if (doRst) begin
         wel_q <= 1'b0;
      end else if (doWren) begin
         wel_q <= 1'b1;
      end else if (doWrdi) begin
         wel_q <= 1'b0;
      end else if (nvDone || engFin) begin
         wel_q <= 1'b0;
      end
   end

   // Only power-on clears these; soft and pin resets keep them
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         nvBits_q <= sfsr_pkg::STATUS_RESET[sfsr_pkg::BIT_SWD:
                                            sfsr_pkg::BIT_PROT_LO];
      end else if (doWrsr) begin
         nvBits_q <= ifc.dat[sfsr_pkg::BIT_SWD:
                             sfsr_pkg::BIT_PROT_LO];
      end
   end

   always_comb begin
      statusNow = sfsr_pkg::STATUS_RESET;
      statusNow[sfsr_pkg::BIT_SWD:sfsr_pkg::BIT_PROT_LO] = nvBits_q;
      statusNow[sfsr_pkg::BIT_WEL]  = wel_q;
      statusNow[sfsr_pkg::BIT_BUSY] = busy;
   end

   // ************************************************************
   // Status word to the link domain
   // ************************************************************
   // New word only once the previous one is acknowledged
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shadow_q <= sfsr_pkg::STATUS_RESET;
         req_q    <= 1'b0;
      end else if (req_q == ackSync && statusNow != shadow_q) begin
         shadow_q <= statusNow;
         req_q    <= ~req_q;
      end
   end

   assign ifc.shadow = shadow_q;
   assign ifc.req    = req_q;

   // ************************************************************
   // Registered outputs
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         engStart   <= 1'b0;
         engOpcode  <= '0;
         engSuspend <= 1'b0;
         engResume  <= 1'b0;
         engAbort   <= 1'b0;
      end else begin
         engStart   <= doEng;
         engSuspend <= doSusp;
         engResume  <= doResume;
         engAbort   <= doRst & ~idle;
         if (doEng) engOpcode <= op;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flashStatus  <= sfsr_pkg::STATUS_RESET;
         protectLevel <= sfsr_pkg::PROT_NONE;
         quadMode     <= 1'b0;
      end else begin
         flashStatus  <= statusNow;
         protectLevel <= nvBits_q[sfsr_pkg::BIT_PROT_HI:
                                  sfsr_pkg::BIT_PROT_LO];
         quadMode     <= nvBits_q[sfsr_pkg::BIT_QUAD];
      end
   end

   // Quad transfers live elsewhere; shared pins are never driven here
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         io2Out <= 1'b0;
         io2Oe  <= 1'b0;
         io3Out <= 1'b0;
         io3Oe  <= 1'b0;
      end else begin
         io2Out <= 1'b0;
         io2Oe  <= 1'b0;
         io3Out <= 1'b0;
         io3Oe  <= 1'b0;
      end
   end
endmodule // sfsr_core
`default_nettype wire

// File: verification/sfsr_core_props.sv
// Purpose: Port-level checks of the flash status register block
// Assumes: Single core clock domain, reset active low
// Notes:   Bound to every sfsr_core instance
`timescale 1ns/100ps
`default_nettype none
module sfsr_core_props #(
   parameter int NV_WRITE_CYC = 8
) (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       csN,
   input wire logic       soOe,
   input wire logic       io2Oe,
   input wire logic       io3Oe,
   input wire logic       engStart,
   input wire logic       engSuspend,
   input wire logic       engDone,
   input wire logic [7:0] flashStatus,
   input wire logic [3:0] protectLevel,
   input wire logic       quadMode
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   prot_mirror_a: assert property (
      protectLevel == flashStatus[5:2]) else $error("protect level off");
   quad_mirror_a: assert property (
      quadMode == flashStatus[6]) else $error("quad mode off");
   shared_pins_a: assert property (
      !io2Oe && !io3Oe) else $error("shared pin driven");
   so_idle_a: assert property (
      csN |-> !soOe) else $error("so driven while deselected");
   start_pulse_a: assert property (
      engStart |=> !engStart) else $error("start longer than one cycle");
   start_busy_a: assert property (
      engStart |-> ##[0:2] flashStatus[0]) else $error("busy not set");
   done_ready_a: assert property (
      $rose(engDone) && flashStatus[0] |-> ##[1:4] flashStatus[1:0] == 2'h0)
      else $error("busy or latch kept after done");
   nv_busy_a: assert property (
      $changed(flashStatus[7:2]) |-> ##[0:1] flashStatus[0])
      else $error("status bits changed without busy");
   wel_ready_a: assert property (
      $rose(flashStatus[1]) |-> !flashStatus[0]) else $error("latch set busy");
   reset_zero_a: assert property (
      $rose(rst_n) |-> flashStatus == 8'h00) else $error("status not zero");
   suspend_busy_a: assert property (
      engSuspend |-> flashStatus[0]) else $error("suspend while idle");
   cover property (engStart);
   cover property (engSuspend);
   cover property ($rose(flashStatus[1]));
endmodule // sfsr_core_props
bind sfsr_core sfsr_core_props #(.NV_WRITE_CYC(NV_WRITE_CYC)) props_inst (
   .clk(clk), .rst_n(rst_n), .csN(csN), .soOe(soOe), .io2Oe(io2Oe),
   .io3Oe(io3Oe), .engStart(engStart), .engSuspend(engSuspend),
   .engDone(engDone), .flashStatus(flashStatus),
   .protectLevel(protectLevel), .quadMode(quadMode));
`default_nettype wire

// File: verification/sfsr_host.sv
// Purpose: Host controller model framing instructions on the link
// Assumes: Mode 0, clock idles low and stops between frames
// Notes:   Bits seen while so is released read as unknown
`timescale 1ns/100ps
`default_nettype none
module sfsr_host (
   output var  logic sck,
   output var  logic csN,
   output var  logic si,
   input  wire logic so,
   input  wire logic soOe
);
   initial begin
      sck = 1'b0;
      csN = 1'b1;
      si = 1'b0;
   end
   task automatic xfer(input logic [23:0] tx, input int nb,
                       output logic [15:0] rx);
      rx = 16'h0000;
      // Odd offset keeps the link out of phase with the core clock
      #17;
      csN = 1'b0;
      for (int i = 0; i < 8 * nb; i++) begin
         si = tx[23 - i];
         #40 sck = 1'b1;
         if (i >= 8) rx = {rx[14:0], soOe ? so : 1'bx};
         #40 sck = 1'b0;
      end
      #40 csN = 1'b1;
      si = ~si;
      #150;
   endtask
endmodule // sfsr_host
`default_nettype wire

// File: verification/tb.sv
// Purpose: Self-checking bench for the flash status register
// Assumes: Host model frames on an 80 ns link clock
// Notes:   Engine handshakes are driven by the bench
`timescale 1ns/100ps
`default_nettype none
module tb;
   localparam int NVW = 800;
   logic        clk, rst_n, wpN, holdRstN, engDone, engSuspended;
   logic        sck, csN, si, soOut, soOe, quadMode;
   logic        engStart, engSuspend, engResume, engAbort;
   logic [7:0]  flashStatus, engOpcode;
   logic [3:0]  protectLevel;
   logic [15:0] rx;
   int          nFail, nTests, nStart, nSusp, nRes, nAbort;
   sfsr_host sfsr_host_inst (.sck(sck), .csN(csN), .si(si), .so(soOut),
      .soOe(soOe));
   sfsr_core #(.NV_WRITE_CYC(NVW)) sfsr_core_inst (
      .clk(clk), .rst_n(rst_n), .sck(sck), .csN(csN), .si(si),
      .soOut(soOut), .soOe(soOe), .wpN(wpN), .io2Out(), .io2Oe(),
      .holdRstN(holdRstN), .io3Out(), .io3Oe(), .engStart(engStart),
      .engOpcode(engOpcode), .engSuspend(engSuspend),
      .engResume(engResume), .engAbort(engAbort), .engDone(engDone),
      .engSuspended(engSuspended), .flashStatus(flashStatus),
      .protectLevel(protectLevel), .quadMode(quadMode));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (engStart === 1'b1) nStart++;
      if (engSuspend === 1'b1) nSusp++;
      if (engResume === 1'b1) nRes++;
      if (engAbort === 1'b1) nAbort++;
   end
   task automatic closeOut;
      if (nFail == 0 && nTests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      nTests++;
      if (g !== e) begin
         nFail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cs(input string nm, input logic [7:0] e);
      chk(nm, {8'h00, e}, {8'h00, flashStatus});
   endtask
   task automatic op(input logic [7:0] o, input logic [7:0] d = 8'h00);
      sfsr_host_inst.xfer({o, d, 8'h00}, (o == 8'h01) ? 2 : 1, rx);
   endtask
   // Second read: the first may still carry a stale frozen byte
   task automatic rd;
      sfsr_host_inst.xfer({sfsr_pkg::OP_READ_STATUS, 16'h0000}, 3, rx);
      sfsr_host_inst.xfer({sfsr_pkg::OP_READ_STATUS, 16'h0000}, 3, rx);
   endtask
   task automatic pulse(input bit sus);
      @(posedge clk);
      if (sus) engSuspended <= 1'b1;
      else engDone <= 1'b1;
      @(posedge clk);
      engSuspended <= 1'b0;
      engDone <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
   initial begin
      #300000;
      nFail++;
      closeOut();
   end
   initial begin
      {nFail, nTests, nStart, nSusp, nRes, nAbort} = '0;
      {rst_n, engDone, engSuspended} = 3'h0;
      wpN = 1'b1;
      holdRstN = 1'b1;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      cs("reset", 8'h00);
      rd();
      chk("read idle", 16'h0000, rx);
      op(sfsr_pkg::OP_WRITE_ENABLE);
      cs("latch set", 8'h02);
      rd();
      chk("read repeat", 16'h0202, rx);
      op(sfsr_pkg::OP_WRITE_DISABLE);
      cs("latch clear", 8'h00);
      op(sfsr_pkg::OP_WRITE_STATUS, 8'hFC);
      cs("write gated", 8'h00);
      op(sfsr_pkg::OP_WRITE_ENABLE);
      op(sfsr_pkg::OP_WRITE_STATUS, 8'h7F);
      op(sfsr_pkg::OP_WRITE_DISABLE);
      rd();
      chk("busy read", 16'h7F7F, rx);
      repeat (NVW) @(posedge clk);
      cs("status written", 8'h7C);
      chk("quad", 16'h0001, {15'h0000, quadMode});
      chk("protect", 16'h000F, {12'h000, protectLevel});
      op(sfsr_pkg::OP_WRITE_ENABLE);
      op(sfsr_pkg::OP_ERASE_ALL_A);
      chk("erase gated", 16'h007E, {8'(nStart), flashStatus});
      // Guard bit on, quad off, so the protect pin counts
      op(sfsr_pkg::OP_WRITE_STATUS, 8'hBC);
      repeat (NVW) @(posedge clk);
      cs("guard set", 8'hBC);
      op(sfsr_pkg::OP_WRITE_ENABLE);
      @(posedge clk) wpN <= 1'b0;
      op(sfsr_pkg::OP_WRITE_STATUS, 8'h00);
      cs("status locked", 8'hBE);
      @(posedge clk) wpN <= 1'b1;
      op(sfsr_pkg::OP_WRITE_STATUS, 8'h00);
      repeat (NVW) @(posedge clk);
      cs("status unlocked", 8'h00);
      op(sfsr_pkg::OP_WRITE_ENABLE);
      op(sfsr_pkg::OP_ERASE_ALL_B);
      chk("erase start", 16'h0160, {8'(nStart), engOpcode});
      cs("erase busy", 8'h03);
      op(sfsr_pkg::OP_SUSPEND);
      pulse(1'b1);
      cs("suspended", 8'h02);
      op(sfsr_pkg::OP_RESUME);
      chk("resume", 16'h0101, {8'(nSusp), 8'(nRes)});
      pulse(1'b0);
      cs("erase done", 8'h00);
      op(sfsr_pkg::OP_WRITE_ENABLE);
      op(sfsr_pkg::OP_ERASE_ALL_A);
      @(posedge clk) holdRstN <= 1'b0;
      repeat (8) @(posedge clk);
      holdRstN <= 1'b1;
      repeat (4) @(posedge clk);
      chk("pin reset", 16'h0201, {8'(nStart), 8'(nAbort)});
      cs("reset idle", 8'h00);
      closeOut();
   end
endmodule // tb
`default_nettype wire
